// file: logic/dcf_consts.svh
// constants for the dual-clock fifo status flag block
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define DCF_CTRL_ADDR 12'h000
`define DCF_STAT_ADDR 12'h004

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DCF_CTRL_THR_LSB 0
`define DCF_CTRL_THR_MSB 9
`define DCF_CTRL_DSEL_LSB 10
`define DCF_CTRL_DSEL_MSB 11
`define DCF_CTRL_CASC_BIT 12

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define DCF_STAT_CNT_LSB 0
`define DCF_STAT_CNT_MSB 11
`define DCF_STAT_EF_BIT 12
`define DCF_STAT_AF_BIT 13
`define DCF_STAT_HF_BIT 14

// ----------------------------------------------------------------
// reset values and depth codes
// ----------------------------------------------------------------
`define DCF_THR_RESET 10'h010
`define DCF_DSEL_512 2'h0
`define DCF_DSEL_1024 2'h1
`define DCF_DSEL_2048 2'h2
`define DCF_DSEL_RESET 2'h2
`define DCF_DEPTH_512 12'h200
`define DCF_DEPTH_1024 12'h400
`define DCF_DEPTH_2048 12'h800

`endif

// file: logic/dcf_pkg.sv
// types for the dual-clock fifo status flag block
`default_nettype none

package dcf_pkg;

    // ------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic rck_s1;
        logic rck_s2;
        logic rck_s3;
        logic wck_s1;
        logic wck_s2;
        logic wck_s3;
        logic ren_n_s1;
        logic ren_n_s2;
        logic wen_n_s1;
        logic wen_n_s2;
        logic [11:0] cnt;
        logic rd_empty;
        logic rd_ae;
        logic wr_full;
        logic wr_af;
        logic wr_half;
        logic ef_n;
        logic af_n;
        logic hf_n;
        logic [9:0] thr;
        logic [1:0] dsel;
        logic casc;
        logic [31:0] prdata;
        logic pslverr;
    } dcf_state_t;

endpackage : dcf_pkg

`default_nettype wire

// file: logic/dcf_flags.sv
// status flag logic of an 18-bit dual-clock fifo with apb control
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.svh"

module dcf_flags
    import dcf_pkg::*;
(
    // system
    input wire logic SYS_CLK,
    input wire logic RST,
    // fifo side pins, asynchronous to SYS_CLK
    input wire logic READ_CLOCK,
    input wire logic WRITE_CLOCK,
    input wire logic READ_ENABLE_N,
    input wire logic WRITE_ENABLE_N,
    // status outputs
    output logic EMPTY_FULL_FLAG_N,
    output logic ALMOST_FLAG_N,
    output logic HALF_FULL_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] depth_of(input logic [1:0] sel);
        case (sel)
            `DCF_DSEL_512: depth_of = `DCF_DEPTH_512;
            `DCF_DSEL_1024: depth_of = `DCF_DEPTH_1024;
            default: depth_of = `DCF_DEPTH_2048;
        endcase
    endfunction : depth_of

    dcf_state_t s_q;
    dcf_state_t s_d;
    logic r_edge;
    logic w_edge;
    logic r_do;
    logic w_do;
    logic [11:0] depth;
    logic [11:0] thr12;
    logic apb_acc;
    logic ctrl_wr;

    assign depth = depth_of(s_q.dsel);
    assign thr12 = {2'h0, s_q.thr};
    // edges seen on the synchronised level, never on the first flop
    assign r_edge = s_q.rck_s2 & ~s_q.rck_s3;
    assign w_edge = s_q.wck_s2 & ~s_q.wck_s3;
    // flags, not the true count, gate transfers: a latent edge only
    // refreshes the flag
    assign r_do = r_edge & ~s_q.ren_n_s2 & ~s_q.rd_empty;
    assign w_do = w_edge & ~s_q.wen_n_s2 & ~s_q.wr_full;
    assign apb_acc = PSEL & PENABLE;
    assign ctrl_wr = apb_acc & PWRITE & (PADDR == `DCF_CTRL_ADDR);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.rck_s1 = READ_CLOCK;
        s_d.rck_s2 = s_q.rck_s1;
        s_d.rck_s3 = s_q.rck_s2;
        s_d.wck_s1 = WRITE_CLOCK;
        s_d.wck_s2 = s_q.wck_s1;
        s_d.wck_s3 = s_q.wck_s2;
        s_d.ren_n_s1 = READ_ENABLE_N;
        s_d.ren_n_s2 = s_q.ren_n_s1;
        s_d.wen_n_s1 = WRITE_ENABLE_N;
        s_d.wen_n_s2 = s_q.wen_n_s1;

        // both sides may move the count in one cycle
        s_d.cnt = s_q.cnt + {11'h000, w_do} - {11'h000, r_do};

        // same-cycle opposite edges are counted in: one legal skew case
        if (r_edge)
        begin
            // every read edge re-evaluates, enabled or not
            s_d.rd_empty = (s_d.cnt == 12'h000);
            s_d.rd_ae = (s_d.cnt <= thr12);
        end
        if (w_edge)
        begin
            // every write edge re-evaluates
            s_d.wr_full = (s_d.cnt == depth);
            s_d.wr_af = (s_d.cnt >= depth - thr12);
            s_d.wr_half = (s_d.cnt > {1'b0, depth[11:1]});
        end

        // stale side keeps its last decision until its own edge
        s_d.ef_n = ~(s_d.rd_empty | s_d.wr_full);
        s_d.af_n = s_d.casc |
            ~(s_d.rd_empty | s_d.rd_ae | s_d.wr_af | s_d.wr_full);
        s_d.hf_n = ~s_d.wr_half;

        // apb: zero wait states, unmapped address answers an error
        s_d.pslverr = 1'b0;
        if (PSEL & ~PENABLE)
        begin
            s_d.prdata = 32'h0000_0000;
            case (PADDR)
                `DCF_CTRL_ADDR:
                begin
                    s_d.prdata[`DCF_CTRL_THR_MSB:`DCF_CTRL_THR_LSB] = s_q.thr;
                    s_d.prdata[`DCF_CTRL_DSEL_MSB:`DCF_CTRL_DSEL_LSB] =
                        s_q.dsel;
                    s_d.prdata[`DCF_CTRL_CASC_BIT] = s_q.casc;
                end
                `DCF_STAT_ADDR:
                begin
                    s_d.prdata[`DCF_STAT_CNT_MSB:`DCF_STAT_CNT_LSB] = s_q.cnt;
                    s_d.prdata[`DCF_STAT_EF_BIT] = s_q.ef_n;
                    s_d.prdata[`DCF_STAT_AF_BIT] = s_q.af_n;
                    s_d.prdata[`DCF_STAT_HF_BIT] = s_q.hf_n;
                end
                default: s_d.pslverr = 1'b1;
            endcase
            if (PWRITE)
            begin
                s_d.prdata = 32'h0000_0000;
                s_d.pslverr = (PADDR != `DCF_CTRL_ADDR) &
                    (PADDR != `DCF_STAT_ADDR);
            end
        end
        else if (apb_acc)
        begin
            s_d.pslverr = s_q.pslverr;
            if (ctrl_wr)
            begin
                // threshold change applies at the next flag update
                s_d.thr = PWDATA[`DCF_CTRL_THR_MSB:`DCF_CTRL_THR_LSB];
                s_d.dsel = PWDATA[`DCF_CTRL_DSEL_MSB:`DCF_CTRL_DSEL_LSB];
                s_d.casc = PWDATA[`DCF_CTRL_CASC_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '0;
            s_q.rd_empty <= 1'b1;
            s_q.ren_n_s1 <= 1'b1;
            s_q.ren_n_s2 <= 1'b1;
            s_q.wen_n_s1 <= 1'b1;
            s_q.wen_n_s2 <= 1'b1;
            s_q.hf_n <= 1'b1;
            s_q.thr <= `DCF_THR_RESET;
            s_q.dsel <= `DCF_DSEL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign EMPTY_FULL_FLAG_N = s_q.ef_n;
    assign ALMOST_FLAG_N = s_q.af_n;
    assign HALF_FULL_N = s_q.hf_n;
    assign PRDATA = s_q.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = s_q.pslverr & apb_acc;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_hold_between_edges;
        @(posedge SYS_CLK) disable iff (RST)
        (!r_edge && !w_edge && !ctrl_wr)
        |=> $stable({s_q.ef_n, s_q.af_n, s_q.hf_n});
    endproperty
    a_hold_between_edges: assert property (p_hold_between_edges)
        else $error("flag outputs moved without a clock edge");

    property p_empty_only_on_read;
        @(posedge SYS_CLK) disable iff (RST)
        !r_edge |=> $stable({s_q.rd_empty, s_q.rd_ae});
    endproperty
    a_empty_only_on_read: assert property (p_empty_only_on_read)
        else $error("empty side flag changed without read edge");

    property p_full_only_on_write;
        @(posedge SYS_CLK) disable iff (RST)
        !w_edge |=> $stable({s_q.wr_full, s_q.wr_af, s_q.wr_half});
    endproperty
    a_full_only_on_write: assert property (p_full_only_on_write)
        else $error("full side flag changed without write edge");

    property p_last_read_empty;
        @(posedge SYS_CLK) disable iff (RST)
        (r_do && !w_do && s_q.cnt == 12'h001 && !s_q.wr_full)
        |=> (s_q.ef_n == 1'b0 && s_q.af_n == s_q.casc && s_q.rd_empty);
    endproperty
    a_last_read_empty: assert property (p_last_read_empty)
        else $error("reading last word did not show empty");

    property p_latent_read;
        @(posedge SYS_CLK) disable iff (RST)
        (r_edge && s_q.rd_empty && !w_edge)
        |=> (s_q.cnt == $past(s_q.cnt));
    endproperty
    a_latent_read: assert property (p_latent_read)
        else $error("latent read edge changed the count");

    property p_latent_write;
        @(posedge SYS_CLK) disable iff (RST)
        (w_edge && s_q.wr_full && !r_edge)
        |=> (s_q.cnt == $past(s_q.cnt));
    endproperty
    a_latent_write: assert property (p_latent_write)
        else $error("latent write edge changed the count");

    property p_write_to_full;
        @(posedge SYS_CLK) disable iff (RST)
        (w_do && !r_do && s_q.cnt == depth - 12'h001)
        |=> (s_q.wr_full && !s_q.ef_n && !s_q.hf_n);
    endproperty
    a_write_to_full: assert property (p_write_to_full)
        else $error("write to last free word did not show full");

    property p_casc_almost;
        @(posedge SYS_CLK) disable iff (RST)
        (s_q.casc && $stable(s_q.casc)) |-> s_q.af_n;
    endproperty
    a_casc_almost: assert property (p_casc_almost)
        else $error("almost flag driven while cascaded");

    property p_zero_thr;
        @(posedge SYS_CLK) disable iff (RST)
        (r_edge && s_q.thr == 10'h000 && s_d.cnt != 12'h000)
        |=> !s_q.rd_ae;
    endproperty
    a_zero_thr: assert property (p_zero_thr)
        else $error("almost empty with zero threshold");

    property p_count_bound;
        @(posedge SYS_CLK) disable iff (RST)
        1'b1 |-> (s_q.cnt <= `DCF_DEPTH_2048);
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("count overflowed");

    property p_read_moves_count;
        @(posedge SYS_CLK) disable iff (RST)
        (r_do && !w_do) |=> (s_q.cnt == $past(s_q.cnt) - 12'h001);
    endproperty
    a_read_moves_count: assert property (p_read_moves_count)
        else $error("enabled read did not lower the count");

    property p_write_moves_count;
        @(posedge SYS_CLK) disable iff (RST)
        (w_do && !r_do) |=> (s_q.cnt == $past(s_q.cnt) + 12'h001);
    endproperty
    a_write_moves_count: assert property (p_write_moves_count)
        else $error("enabled write did not raise the count");

    property p_disabled_read;
        @(posedge SYS_CLK) disable iff (RST)
        (r_edge && s_q.ren_n_s2 && !w_do) |=> $stable(s_q.cnt);
    endproperty
    a_disabled_read: assert property (p_disabled_read)
        else $error("disabled read edge changed the count");

    property p_disabled_write;
        @(posedge SYS_CLK) disable iff (RST)
        (w_edge && s_q.wen_n_s2 && !r_do) |=> $stable(s_q.cnt);
    endproperty
    a_disabled_write: assert property (p_disabled_write)
        else $error("disabled write edge changed the count");

    property p_latent_read_clears;
        @(posedge SYS_CLK) disable iff (RST)
        (r_edge && s_q.rd_empty && s_q.cnt != 12'h000) |=> !s_q.rd_empty;
    endproperty
    a_latent_read_clears: assert property (p_latent_read_clears)
        else $error("latent read edge did not leave empty");

    property p_latent_write_clears;
        @(posedge SYS_CLK) disable iff (RST)
        (w_edge && s_q.wr_full && !r_do && s_q.cnt != depth)
        |=> !s_q.wr_full;
    endproperty
    a_latent_write_clears: assert property (p_latent_write_clears)
        else $error("latent write edge did not leave full");

    property p_no_underflow;
        @(posedge SYS_CLK) disable iff (RST)
        r_do |-> (s_q.cnt != 12'h000);
    endproperty
    a_no_underflow: assert property (p_no_underflow)
        else $error("read taken from an empty store");

    property p_count_needs_edge;
        @(posedge SYS_CLK) disable iff (RST)
        (!r_edge && !w_edge) |=> $stable(s_q.cnt);
    endproperty
    a_count_needs_edge: assert property (p_count_needs_edge)
        else $error("count moved without a clock edge");

    property p_both_moves;
        @(posedge SYS_CLK) disable iff (RST)
        (r_do && w_do) |=> $stable(s_q.cnt);
    endproperty
    a_both_moves: assert property (p_both_moves)
        else $error("same cycle read and write lost a word");

    property p_read_reevaluates;
        @(posedge SYS_CLK) disable iff (RST)
        r_edge |=> (s_q.rd_empty == (s_q.cnt == 12'h000));
    endproperty
    a_read_reevaluates: assert property (p_read_reevaluates)
        else $error("empty flag stale after read edge");

    property p_write_reevaluates;
        @(posedge SYS_CLK) disable iff (RST)
        (w_edge && !ctrl_wr) |=> (s_q.wr_full == (s_q.cnt == depth));
    endproperty
    a_write_reevaluates: assert property (p_write_reevaluates)
        else $error("full flag stale after write edge");

endmodule : dcf_flags

`default_nettype wire

// file: logic/README_unused.sv
// intentionally empty design unit list
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: tb/dcf_pins.sv
// fifo-side pin model: writer and reader clock and enable pins
`timescale 1ns/1ps
`default_nettype none

module dcf_pins
(
    // system
    input wire logic clk,
    // fifo pins
    output logic read_clock,
    output logic write_clock,
    output logic read_enable_n,
    output logic write_enable_n
);
    initial
    begin
        read_clock = 1'b0;
        write_clock = 1'b0;
        read_enable_n = 1'b1;
        write_enable_n = 1'b1;
    end

    // ------------------------------------------------------------
    // one clock pulse on either or both pins
    // ------------------------------------------------------------
    // enables settle two cycles ahead of the edge so the read or
    // write enable is through its two-flop synchroniser when the edge is seen
    task automatic pulse(input logic rd, input logic wr,
        input logic ren_n, input logic wen_n);
        @(posedge clk);
        read_enable_n <= ren_n;
        write_enable_n <= wen_n;
        repeat (2) @(posedge clk);
        read_clock <= rd;
        write_clock <= wr;
        repeat (3) @(posedge clk);
        read_clock <= 1'b0;
        write_clock <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
endmodule : dcf_pins

`default_nettype wire

// file: tb/dual_clock_fifo_status_flags_tb_top.sv
// self-checking bench for the fifo status flag block
`timescale 1ns/1ps
`default_nettype none
`include "dcf_consts.svh"

module dual_clock_fifo_status_flags_tb_top;
    import dcf_pkg::*;
    logic sys_clk, rst, psel, penable, pwrite, ef_n, af_n, hf_n;
    logic pready, pslverr, rck, wck, ren_n, wen_n, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares = 0;
    int n_checks = 0;

    dcf_pins side (.clk(sys_clk), .read_clock(rck), .write_clock(wck),
        .read_enable_n(ren_n), .write_enable_n(wen_n));
    dcf_flags dut (.SYS_CLK(sys_clk), .RST(rst), .READ_CLOCK(rck),
        .WRITE_CLOCK(wck), .READ_ENABLE_N(ren_n),
        .WRITE_ENABLE_N(wen_n), .EMPTY_FULL_FLAG_N(ef_n),
        .ALMOST_FLAG_N(af_n), .HALF_FULL_N(hf_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset();
        rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic cnt(input logic [11:0] exp);
        apb(1'b0, `DCF_STAT_ADDR, 32'h0000_0000);
        chk("count", {20'h0_0000, rd[11:0]}, {20'h0_0000, exp});
    endtask : cnt

    task automatic fl(input logic [2:0] exp);
        chk("flags", {29'h0, ef_n, af_n, hf_n}, {29'h0, exp});
    endtask : fl

    task automatic fill(input int n);
        repeat (n) side.pulse(1'b0, 1'b1, 1'b1, 1'b0);
    endtask : fill

    task automatic sync();
        side.pulse(1'b1, 1'b1, 1'b1, 1'b1);
    endtask : sync

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        fl(3'b001);
        apb(1'b0, `DCF_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_0810);
        apb(1'b1, `DCF_STAT_ADDR, 32'h0000_0fff);
        apb(1'b0, `DCF_STAT_ADDR, 32'h0000_0000);
        chk("stat", rd, 32'h0000_4000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("slverr", {31'h0, err}, 32'h0000_0001);
        chk("unmapped", rd, 32'h0000_0000);
    endtask : t_reset

    task automatic t_empty();
        fill(1);
        fl(3'b001);
        side.pulse(1'b1, 1'b0, 1'b1, 1'b1);
        fl(3'b101);
        cnt(12'h001);
        side.pulse(1'b1, 1'b0, 1'b0, 1'b1);
        fl(3'b001);
        side.pulse(1'b1, 1'b0, 1'b0, 1'b1);
        fl(3'b001);
        cnt(12'h000);
    endtask : t_empty

    task automatic t_default();
        fill(16);
        sync();
        fl(3'b101);
        fill(1);
        sync();
        fl(3'b111);
        side.pulse(1'b1, 1'b1, 1'b0, 1'b0);
        cnt(12'h011);
    endtask : t_default

    task automatic t_small();
        apb(1'b1, `DCF_CTRL_ADDR, 32'h0000_0002);
        fill(3);
        sync();
        fl(3'b111);
        fill(254);
        sync();
        fl(3'b110);
        fill(253);
        sync();
        fl(3'b100);
        fill(2);
        fl(3'b000);
        fill(1);
        cnt(12'h200);
        side.pulse(1'b1, 1'b0, 1'b0, 1'b1);
        fl(3'b000);
        cnt(12'h1ff);
        side.pulse(1'b0, 1'b1, 1'b1, 1'b1);
        fl(3'b100);
        cnt(12'h1ff);
        fill(1);
        fl(3'b000);
        cnt(12'h200);
    endtask : t_small

    task automatic t_zero();
        apb(1'b1, `DCF_CTRL_ADDR, 32'h0000_0400);
        fill(1);
        sync();
        fl(3'b111);
        apb(1'b1, `DCF_CTRL_ADDR, 32'h0000_1400);
        apb(1'b0, `DCF_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_1400);
        side.pulse(1'b1, 1'b0, 1'b0, 1'b1);
        fl(3'b011);
        fill(513);
        sync();
        fl(3'b110);
    endtask : t_zero

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        do_reset();
        t_reset();
        t_empty();
        t_default();
        do_reset();
        t_small();
        do_reset();
        t_zero();
        end_of_test();
    end

    // full run is near 10k cycles; three times that is ample
    initial
    begin
        #300_000;
        miscompares++;
        end_of_test();
    end
endmodule : dual_clock_fifo_status_flags_tb_top

`default_nettype wire
